// *** logic/tfpc_top.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "tfpc_regs.svh"
module tfpc_top
	import tfpc_pkg::*;
#(
	parameter int TRACKS = 8,
	parameter int DEB_CYCLES = `TFPC_DEB_MS * `TFPC_NS_PER_MS / `TFPC_CLK_NS,
	parameter int FLASH_CYCLES =
		`TFPC_FLASH_MS * `TFPC_NS_PER_MS / `TFPC_CLK_NS
)(
	input wire logic sys_clk, // 20 MHz system clock
	input wire logic rst_n, // Async reset, active low
	input wire logic fs_raw, // Footswitch contact
	input wire logic fs_invert, // Footswitch polarity invert
	input wire logic key_play, // Play key pulse
	input wire logic key_pause, // Pause key pulse
	input wire logic key_stop, // Stop key pulse
	input wire logic panel_set, // Other panel key selects a mode
	input wire tfpc_mode_t panel_mode, // Mode chosen by that key
	input wire logic [TRACKS-1:0] track_arm_button, // Track arm buttons
	input wire logic locate_done, // Pre-roll point reached
	input wire logic pitch_key, // Pitch key pulse
	input wire logic enter_key, // Enter key pulse
	input wire logic shuttle_left, // Shuttle left pulse
	input wire logic shuttle_right, // Shuttle right pulse
	input wire logic dial_up, // Dial step up
	input wire logic dial_down, // Dial step down
	input wire logic [15:0] nv_offset, // Stored offset at power-on
	output tfpc_mode_t mode, // Current transport mode
	output logic locate_req, // Locate pre-roll request
	output logic rehearse_lamp, // Rehearse lamp
	output logic record_lamp, // Record lamp
	output logic play_lamp, // Play lamp
	output logic pitch_active, // Pitch function open
	output logic variable_pitch_select, // Variable pitch chosen
	output logic fix_flash, // Nominal selection flashing
	output logic [15:0] display_offset, // Offset shown
	output logic [15:0] pitch_offset, // Offset to keep across power-off
	output logic [15:0] rate_request // Transport rate request
);
	localparam int FW = $clog2(FLASH_CYCLES + 1);

	// Lamp codes per mode: rehearse, record, play
	function automatic logic [5:0] lamp_of(input tfpc_mode_t m);
		unique case (m)
			TFPC_PLAY, TFPC_CUE_REVIEW:
				lamp_of = {`TFPC_LAMP_OFF, `TFPC_LAMP_OFF, `TFPC_LAMP_ON};
			TFPC_PLAY_PAUSE:
				lamp_of = {`TFPC_LAMP_OFF, `TFPC_LAMP_OFF, `TFPC_LAMP_FLASH};
			TFPC_REC_PAUSE, TFPC_NEW_REC_PAUSE, TFPC_AP_REC_STANDBY,
			TFPC_AP_REC_LOCATE:
				lamp_of = {`TFPC_LAMP_OFF, `TFPC_LAMP_FLASH, `TFPC_LAMP_OFF};
			TFPC_REHEARSE_LAMP_PAUSE, TFPC_AP_REHEARSE_LAMP_STANDBY, TFPC_AP_REHEARSE_LAMP_LOCATE:
				lamp_of = {`TFPC_LAMP_FLASH, `TFPC_LAMP_OFF, `TFPC_LAMP_OFF};
			TFPC_PLAY_REC_WAIT, TFPC_AP_REC_WAIT:
				lamp_of = {`TFPC_LAMP_OFF, `TFPC_LAMP_FLASH, `TFPC_LAMP_ON};
			TFPC_PLAY_REHEARSE_LAMP_WAIT, TFPC_AP_REHEARSE_LAMP_WAIT:
				lamp_of = {`TFPC_LAMP_FLASH, `TFPC_LAMP_OFF, `TFPC_LAMP_ON};
			TFPC_RECORD, TFPC_NEW_REC:
				lamp_of = {`TFPC_LAMP_OFF, `TFPC_LAMP_ON, `TFPC_LAMP_ON};
			TFPC_REHEARSE:
				lamp_of = {`TFPC_LAMP_ON, `TFPC_LAMP_OFF, `TFPC_LAMP_ON};
			default:
				lamp_of = {`TFPC_LAMP_OFF, `TFPC_LAMP_OFF, `TFPC_LAMP_OFF};
		endcase
	endfunction

	// Clamp a widened offset into the legal pitch range
	function automatic logic [15:0] clamp(input logic [16:0] v);
		if ($signed(v) < $signed(17'($signed(`TFPC_PITCH_MIN))))
			clamp = `TFPC_PITCH_MIN;
		else if ($signed(v) > $signed({1'b0, `TFPC_PITCH_MAX}))
			clamp = `TFPC_PITCH_MAX;
		else
			clamp = v[15:0];
	endfunction

	////////////////////////////////////////////////////////////////
	// Footswitch conditioning
	tfpc_fs_if fs ();
	assign fs.raw = fs_raw;
	assign fs.invert = fs_invert;

	tfpc_debounce #(
		.DEB_CYCLES(DEB_CYCLES)
	) u_deb (
		.sys_clk(sys_clk),
		.rst_n(rst_n),
		.fs(fs.cond)
	);

	////////////////////////////////////////////////////////////////
	// Transport sequencer
	tfpc_mode_t next_mode;
	tfpc_mode_t adv_mode;
	wire logic advance = fs.press || key_play;
	wire logic armed = |track_arm_button;

	// Successor of each mode on a play-equivalent press
	always_comb
	begin
		adv_mode = mode;
		unique case (mode)
			TFPC_STOP, TFPC_PLAY_PAUSE, TFPC_CUE_REVIEW,
			TFPC_RECORD, TFPC_REHEARSE:
				adv_mode = TFPC_PLAY;
			TFPC_PLAY:
				adv_mode = TFPC_PLAY_PAUSE;
			TFPC_REC_PAUSE:
				adv_mode = TFPC_PLAY_REC_WAIT;
			TFPC_REHEARSE_LAMP_PAUSE:
				adv_mode = TFPC_PLAY_REHEARSE_LAMP_WAIT;
			TFPC_PLAY_REC_WAIT:
				adv_mode = armed ? TFPC_RECORD : TFPC_PLAY_REC_WAIT;
			TFPC_PLAY_REHEARSE_LAMP_WAIT:
				adv_mode = TFPC_REHEARSE;
			TFPC_NEW_REC_PAUSE:
				adv_mode = TFPC_NEW_REC;
			TFPC_NEW_REC:
				adv_mode = TFPC_STOP;
			TFPC_AP_REC_STANDBY:
				adv_mode = TFPC_AP_REC_LOCATE;
			TFPC_AP_REHEARSE_LAMP_STANDBY:
				adv_mode = TFPC_AP_REHEARSE_LAMP_LOCATE;
			TFPC_AP_REC_LOCATE, TFPC_AP_REHEARSE_LAMP_LOCATE,
			TFPC_AP_REC_WAIT, TFPC_AP_REHEARSE_LAMP_WAIT:
				adv_mode = mode;
			default:
				adv_mode = TFPC_STOP;
		endcase
	end

	// Stop wins, then play-equivalent presses, pause, locate, other keys
	always_comb
	begin
		next_mode = mode;
		if (key_stop)
			next_mode = TFPC_STOP;
		else if (advance)
			next_mode = adv_mode;
		else if (key_pause && mode == TFPC_PLAY)
			next_mode = TFPC_PLAY_PAUSE;
		else if (locate_done && mode == TFPC_AP_REC_LOCATE)
			next_mode = TFPC_AP_REC_WAIT;
		else if (locate_done && mode == TFPC_AP_REHEARSE_LAMP_LOCATE)
			next_mode = TFPC_AP_REHEARSE_LAMP_WAIT;
		else if (panel_set)
			next_mode = panel_mode;
	end

	always_ff @(posedge sys_clk or negedge rst_n)
		if (!rst_n)
			mode <= TFPC_STOP;
		else
			mode <= next_mode;

	assign locate_req = mode == TFPC_AP_REC_LOCATE ||
		mode == TFPC_AP_REHEARSE_LAMP_LOCATE;

	////////////////////////////////////////////////////////////////
	// Lamp drive with a shared flash phase
	logic [FW-1:0] flash_cnt;
	logic flash_phase;
	wire logic [5:0] lamp_code = lamp_of(mode);
	wire logic flash_wrap = flash_cnt == FW'(FLASH_CYCLES - 1);

	function automatic logic lamp_level(input logic [1:0] c, input logic ph);
		lamp_level = c == `TFPC_LAMP_ON || (c == `TFPC_LAMP_FLASH && ph);
	endfunction

	always_ff @(posedge sys_clk or negedge rst_n)
		if (!rst_n)
		begin
			flash_cnt <= '0;
			flash_phase <= 1'b0;
			rehearse_lamp <= 1'b0;
			record_lamp <= 1'b0;
			play_lamp <= 1'b0;
		end
		else
		begin
			flash_cnt <= flash_wrap ? '0 : flash_cnt + FW'(1);
			flash_phase <= flash_phase ^ flash_wrap;
			rehearse_lamp <= lamp_level(lamp_code[5:4], flash_phase);
			record_lamp <= lamp_level(lamp_code[3:2], flash_phase);
			play_lamp <= lamp_level(lamp_code[1:0], flash_phase);
		end

	////////////////////////////////////////////////////////////////
	// Pitch selection and offset
	logic restored;
	logic [15:0] next_offset;
	wire logic tune = pitch_active && variable_pitch_select;

	// Restore the kept offset once after power-on, then dial it in range
	always_comb
	begin
		next_offset = pitch_offset;
		if (!restored)
			next_offset = clamp({nv_offset[15], nv_offset});
		else if (tune && dial_up && !dial_down)
			next_offset = clamp({pitch_offset[15], pitch_offset} +
				`TFPC_PITCH_STEP);
		else if (tune && dial_down && !dial_up)
			next_offset = clamp({pitch_offset[15], pitch_offset} -
				`TFPC_PITCH_STEP);
	end

	always_ff @(posedge sys_clk or negedge rst_n)
		if (!rst_n)
		begin
			restored <= 1'b0;
			pitch_offset <= `TFPC_PITCH_ZERO;
			pitch_active <= 1'b0;
			variable_pitch_select <= 1'b0;
		end
		else
		begin
			restored <= 1'b1;
			pitch_offset <= next_offset;
			if (pitch_key)
				pitch_active <= 1'b1;
			else if (enter_key)
				pitch_active <= 1'b0;
			if (pitch_active && shuttle_left)
				variable_pitch_select <= 1'b0;
			else if (pitch_active && shuttle_right)
				variable_pitch_select <= 1'b1;
		end

	// Display and rate follow the selection
	always_ff @(posedge sys_clk or negedge rst_n)
		if (!rst_n)
		begin
			fix_flash <= 1'b0;
			display_offset <= `TFPC_PITCH_ZERO;
			rate_request <= `TFPC_RATE_NOMINAL;
		end
		else
		begin
			fix_flash <= (pitch_active || pitch_key) &&
				!variable_pitch_select;
			display_offset <= variable_pitch_select ? pitch_offset :
				`TFPC_PITCH_ZERO;
			rate_request <= variable_pitch_select ?
				`TFPC_RATE_NOMINAL + pitch_offset :
				`TFPC_RATE_NOMINAL;
		end

	////////////////////////////////////////////////////////////////
	// Checks
	wire logic plain_adv = advance && !key_stop;

	chk_stop_to_play: assert property (@(posedge sys_clk) disable iff (!rst_n) fs.press && !key_stop && mode == TFPC_STOP |=> mode == TFPC_PLAY) else $error("footswitch did not start play");
	chk_play_pause_toggle: assert property (@(posedge sys_clk) disable iff (!rst_n) plain_adv && mode == TFPC_PLAY |=> mode == TFPC_PLAY_PAUSE) else $error("play did not pause");
	chk_pause_to_play: assert property (@(posedge sys_clk) disable iff (!rst_n) plain_adv && mode == TFPC_PLAY_PAUSE |=> mode == TFPC_PLAY) else $error("pause did not resume play");
	chk_wait_to_record: assert property (@(posedge sys_clk) disable iff (!rst_n) plain_adv && mode == TFPC_PLAY_REC_WAIT && armed |=> mode == TFPC_RECORD) else $error("armed wait did not record");
	chk_wait_unarmed_hold: assert property (@(posedge sys_clk) disable iff (!rst_n) plain_adv && mode == TFPC_PLAY_REC_WAIT && !armed |=> mode == TFPC_PLAY_REC_WAIT) else $error("record entered with no track armed");
	chk_new_rec_stop: assert property (@(posedge sys_clk) disable iff (!rst_n) plain_adv && mode == TFPC_NEW_REC ##1 !panel_set |=> !rehearse_lamp && !record_lamp && !play_lamp) else $error("new recording did not stop dark");
	chk_ap_locate_first: assert property (@(posedge sys_clk) disable iff (!rst_n) plain_adv && mode == TFPC_AP_REC_STANDBY |=> locate_req && mode != TFPC_AP_REC_WAIT) else $error("auto punch skipped the locate");
	chk_wait_lamps: assert property (@(posedge sys_clk) disable iff (!rst_n) mode == TFPC_PLAY_REC_WAIT && $stable(mode) |=> play_lamp && !rehearse_lamp) else $error("record wait lamps wrong");
	chk_pitch_range: assert property (@(posedge sys_clk) disable iff (!rst_n) restored |-> $signed(pitch_offset) >= $signed(`TFPC_PITCH_MIN) && $signed(pitch_offset) <= $signed(`TFPC_PITCH_MAX)) else $error("pitch offset out of range");
	chk_pitch_entry: assert property (@(posedge sys_clk) disable iff (!rst_n) pitch_key && !variable_pitch_select && !shuttle_right |=> fix_flash && display_offset == `TFPC_PITCH_ZERO) else $error("pitch entry not nominal");
	chk_shuttle_restore: assert property (@(posedge sys_clk) disable iff (!rst_n) restored && pitch_active && shuttle_right && !shuttle_left && !dial_up && !dial_down |=> variable_pitch_select && pitch_offset == $past(pitch_offset)) else $error("variable pitch altered offset");
	chk_rate_nominal: assert property (@(posedge sys_clk) disable iff (!rst_n) !variable_pitch_select |=> rate_request == `TFPC_RATE_NOMINAL) else $error("rate moved at nominal pitch");

	cov_punch_sequence: cover property (@(posedge sys_clk) disable iff (!rst_n) mode == TFPC_PLAY_REC_WAIT ##1 mode == TFPC_RECORD);
	cov_new_rec_stop: cover property (@(posedge sys_clk) disable iff (!rst_n) mode == TFPC_NEW_REC ##1 mode == TFPC_STOP);
	cov_locate_wait: cover property (@(posedge sys_clk) disable iff (!rst_n) locate_req ##1 mode == TFPC_AP_REHEARSE_LAMP_WAIT);
	cov_variable_rate: cover property (@(posedge sys_clk) disable iff (!rst_n) variable_pitch_select && rate_request != `TFPC_RATE_NOMINAL);

endmodule // tfpc_top
`default_nettype wire

// *** logic/tfpc_regs.svh ***
`ifndef TFPC_REGS_SVH
`define TFPC_REGS_SVH

// Clock period and timing figures
`define TFPC_CLK_NS 50
`define TFPC_DEB_MS 10
`define TFPC_FLASH_MS 250
`define TFPC_NS_PER_MS 1000000

// Lamp drive codes
`define TFPC_LAMP_OFF 2'h0
`define TFPC_LAMP_ON 2'h1
`define TFPC_LAMP_FLASH 2'h2

// Pitch offset in hundredths of a percent, two's complement
`define TFPC_PITCH_MIN 16'hFB4D
`define TFPC_PITCH_MAX 16'h04B4
`define TFPC_PITCH_ZERO 16'h0000
`define TFPC_PITCH_STEP 17'h00001
// Nominal rate, in hundredths of a percent of nominal speed
`define TFPC_RATE_NOMINAL 16'h2710

`endif

// *** logic/tfpc_pkg.sv ***
`default_nettype none
package tfpc_pkg;

	// Transport modes
	typedef enum logic [4:0] {
		TFPC_STOP,
		TFPC_PLAY,
		TFPC_PLAY_PAUSE,
		TFPC_CUE_REVIEW,
		TFPC_REC_PAUSE,
		TFPC_REHEARSE_LAMP_PAUSE,
		TFPC_PLAY_REC_WAIT,
		TFPC_PLAY_REHEARSE_LAMP_WAIT,
		TFPC_RECORD,
		TFPC_REHEARSE,
		TFPC_NEW_REC_PAUSE,
		TFPC_NEW_REC,
		TFPC_AP_REC_STANDBY,
		TFPC_AP_REHEARSE_LAMP_STANDBY,
		TFPC_AP_REC_LOCATE,
		TFPC_AP_REHEARSE_LAMP_LOCATE,
		TFPC_AP_REC_WAIT,
		TFPC_AP_REHEARSE_LAMP_WAIT
	} tfpc_mode_t;

endpackage
`default_nettype wire

// *** logic/tfpc_fs_if.sv ***
`timescale 1ns/1ps
`default_nettype none
// Footswitch path between the conditioner and the sequencer
interface tfpc_fs_if;
	logic raw;
	logic invert;
	logic press;
	modport cond (input raw, input invert, output press);
	modport seq (output raw, output invert, input press);
endinterface
`default_nettype wire

// *** logic/tfpc_debounce.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "tfpc_regs.svh"
module tfpc_debounce
	import tfpc_pkg::*;
#(
	parameter int DEB_CYCLES = `TFPC_DEB_MS * `TFPC_NS_PER_MS / `TFPC_CLK_NS
)(
	input wire logic sys_clk, // System clock
	input wire logic rst_n, // Async reset, active low
	tfpc_fs_if.cond fs // Footswitch path
);
	localparam int CW = $clog2(DEB_CYCLES + 1);

	logic sync1;
	logic sync2;
	logic stable;
	logic stable_q;
	logic [CW-1:0] cnt;
	wire logic active = sync2 ^ fs.invert; // Polarity option
	wire logic differs = active != stable;
	wire logic settled = cnt == CW'(DEB_CYCLES - 1);

	////////////////////////////////////////////////////////////////
	// Two-flop synchroniser
	always_ff @(posedge sys_clk or negedge rst_n)
		if (!rst_n)
		begin
			sync1 <= 1'b0;
			sync2 <= 1'b0;
		end
		else
		begin
			sync1 <= fs.raw;
			sync2 <= sync1;
		end

	// Accept a new level only after it has held for the full window
	always_ff @(posedge sys_clk or negedge rst_n)
		if (!rst_n)
		begin
			cnt <= '0;
			stable <= 1'b0;
			stable_q <= 1'b0;
		end
		else
		begin
			cnt <= (differs && !settled) ? cnt + CW'(1) : '0;
			if (differs && settled)
				stable <= active;
			stable_q <= stable;
		end

	// Act on the press edge only
	assign fs.press = stable && !stable_q;

	chk_press_single_pulse: assert property (@(posedge sys_clk) disable iff (!rst_n) fs.press |=> !fs.press) else $error("footswitch press longer than one cycle");
	chk_press_after_hold: assert property (@(posedge sys_clk) disable iff (!rst_n) fs.press |-> $past(stable) == 1'b0 && $past(differs)) else $error("press without a settled new level");

endmodule // tfpc_debounce
`default_nettype wire

// *** sim/tfpc_fs_pedal.sv ***
`timescale 1ns/1ps
`default_nettype none
// Footswitch contact that chatters on every change of the pedal
module tfpc_fs_pedal (
	input wire logic sys_clk, // System clock
	input wire logic down, // Pedal held down
	input wire logic invert, // Switch is active low
	output logic fs_raw // Contact level
);
	logic last = 1'b0;
	int n = 0;
	initial fs_raw = 1'b0;
	// Two cycles of chatter, shorter than the filter, then settle
	always @(posedge sys_clk)
	begin
		if (down !== last)
		begin
			last = down;
			n = 3;
		end
		if (n > 1)
			fs_raw <= ~fs_raw;
		else
			fs_raw <= down ^ invert;
		if (n > 0)
			n = n - 1;
	end
endmodule // tfpc_fs_pedal
`default_nettype wire

// *** sim/tfpc_top_test.sv ***
`timescale 1ns/1ps
`default_nettype none
module tfpc_top_test;
	import tfpc_pkg::*;
	localparam logic [1:0] OF = 2'h1; // Never lit
	localparam logic [1:0] ON = 2'h2; // Never dark
	localparam logic [1:0] FL = 2'h3; // Both seen
	localparam int FS = 11; // Pedal press and release
	logic sys_clk = 1'b0;
	logic rst_n = 1'b0;
	logic fs_invert = 1'b0;
	logic down = 1'b0;
	logic fs_raw;
	logic [10:0] kv = 11'h000;
	tfpc_mode_t panel_mode = TFPC_STOP;
	logic [7:0] track_arm_button = 8'h00;
	logic [15:0] nv_offset = 16'hFB4E;
	wire logic key_play, key_pause, key_stop, panel_set, locate_done;
	wire logic pitch_key, enter_key, shuttle_left, shuttle_right;
	wire logic dial_up, dial_down;
	tfpc_mode_t mode;
	logic locate_req, rehearse_lamp, record_lamp, play_lamp;
	logic pitch_active, variable_pitch_select, fix_flash;
	logic [15:0] display_offset, pitch_offset, rate_request;
	int fail_count = 0;
	int n_checks = 0;
	// Key pulses by index
	assign {dial_down, dial_up, shuttle_right, shuttle_left, enter_key,
		pitch_key, locate_done, panel_set, key_stop, key_pause,
		key_play} = kv;
	always #25 sys_clk = ~sys_clk;
	tfpc_top #(.TRACKS(8), .DEB_CYCLES(4), .FLASH_CYCLES(4)) u_dut (
		.sys_clk, .rst_n, .fs_raw, .fs_invert, .key_play, .key_pause,
		.key_stop, .panel_set, .panel_mode, .track_arm_button,
		.locate_done, .pitch_key, .enter_key, .shuttle_left,
		.shuttle_right, .dial_up, .dial_down, .nv_offset, .mode,
		.locate_req, .rehearse_lamp, .record_lamp, .play_lamp,
		.pitch_active, .variable_pitch_select, .fix_flash,
		.display_offset, .pitch_offset, .rate_request);
	tfpc_fs_pedal u_pedal (.sys_clk, .down, .invert(fs_invert), .fs_raw);
	////////////////////////////////////////////////////////////////////
	task close_out;
		$display("Checks %0d, mismatches %0d", n_checks, fail_count);
		if (fail_count == 0 && n_checks > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	task chk(input logic [15:0] got, input logic [15:0] exp, string s);
		n_checks++;
		if (got !== exp)
		begin
			fail_count++;
			$display("Error at %0t: %s got %h want %h", $time, s, got, exp);
		end
	endtask
	// One key pulse, or a whole pedal press with release
	task hit(input int k, input tfpc_mode_t m);
		@(negedge sys_clk);
		panel_mode = m;
		if (k == FS)
		begin
			down = 1'b1;
			repeat (20) @(negedge sys_clk);
			down = 1'b0;
			repeat (20) @(negedge sys_clk);
		end
		else
		begin
			kv[k] = 1'b1;
			@(negedge sys_clk);
			kv[k] = 1'b0;
		end
		repeat (2) @(negedge sys_clk);
	endtask
	// Lamp pattern over twelve cycles, two bits per lamp
	task lamps(input logic [5:0] e);
		logic [2:0] hi, lo, l;
		hi = 3'h0;
		lo = 3'h0;
		repeat (12)
		begin
			@(negedge sys_clk);
			l = {rehearse_lamp, record_lamp, play_lamp};
			hi = hi | l;
			lo = lo | ~l;
		end
		for (int i = 0; i < 3; i++)
			chk({14'h0000, hi[i], lo[i]}, {14'h0000, e[2*i+:2]}, "lamp");
	endtask
	task go(input int k, input tfpc_mode_t m, input logic [5:0] e);
		hit(k, m);
		chk(16'(mode), 16'(m), "mode");
		lamps(e);
	endtask
	////////////////////////////////////////////////////////////////////
	task t_playback;
		go(FS, TFPC_PLAY, {OF, OF, ON});
		go(FS, TFPC_PLAY_PAUSE, {OF, OF, FL});
		go(FS, TFPC_PLAY, {OF, OF, ON});
		go(2, TFPC_STOP, {OF, OF, OF});
		go(0, TFPC_PLAY, {OF, OF, ON});
		go(1, TFPC_PLAY_PAUSE, {OF, OF, FL});
		go(3, TFPC_CUE_REVIEW, {OF, OF, ON});
		go(FS, TFPC_PLAY, {OF, OF, ON});
		$display("Test playback done");
	endtask
	task t_punch;
		go(3, TFPC_REC_PAUSE, {OF, FL, OF});
		go(FS, TFPC_PLAY_REC_WAIT, {OF, FL, ON});
		go(FS, TFPC_PLAY_REC_WAIT, {OF, FL, ON});
		track_arm_button = 8'h80;
		go(FS, TFPC_RECORD, {OF, ON, ON});
		go(FS, TFPC_PLAY, {OF, OF, ON});
		go(FS, TFPC_PLAY_PAUSE, {OF, OF, FL});
		go(3, TFPC_REHEARSE_LAMP_PAUSE, {FL, OF, OF});
		go(FS, TFPC_PLAY_REHEARSE_LAMP_WAIT, {FL, OF, ON});
		go(FS, TFPC_REHEARSE, {ON, OF, ON});
		go(FS, TFPC_PLAY, {OF, OF, ON});
		$display("Test punch done");
	endtask
	task t_new_rec;
		go(3, TFPC_NEW_REC_PAUSE, {OF, FL, OF});
		go(FS, TFPC_NEW_REC, {OF, ON, ON});
		go(FS, TFPC_STOP, {OF, OF, OF});
		$display("Test new recording done");
	endtask
	task t_auto;
		go(3, TFPC_AP_REC_STANDBY, {OF, FL, OF});
		go(FS, TFPC_AP_REC_LOCATE, {OF, FL, OF});
		chk(16'(locate_req), 16'h0001, "locate");
		go(FS, TFPC_AP_REC_LOCATE, {OF, FL, OF});
		go(4, TFPC_AP_REC_WAIT, {OF, FL, ON});
		chk(16'(locate_req), 16'h0000, "locate");
		go(3, TFPC_AP_REHEARSE_LAMP_STANDBY, {FL, OF, OF});
		go(FS, TFPC_AP_REHEARSE_LAMP_LOCATE, {FL, OF, OF});
		go(4, TFPC_AP_REHEARSE_LAMP_WAIT, {FL, OF, ON});
		$display("Test auto punch done");
	endtask
	task t_pitch;
		hit(5, TFPC_STOP);
		chk(16'(pitch_active), 16'h0001, "open");
		chk(16'(fix_flash), 16'h0001, "flash");
		chk(display_offset, 16'h0000, "disp");
		hit(8, TFPC_STOP);
		chk(display_offset, 16'hFB4E, "disp");
		chk(rate_request, 16'h225E, "rate");
		hit(10, TFPC_STOP);
		hit(10, TFPC_STOP);
		chk(display_offset, 16'hFB4D, "disp");
		chk(rate_request, 16'h225D, "rate");
		hit(7, TFPC_STOP);
		chk(16'(variable_pitch_select), 16'h0000, "var");
		chk(rate_request, 16'h2710, "rate");
		hit(8, TFPC_STOP);
		chk(display_offset, 16'hFB4D, "disp");
		hit(6, TFPC_STOP);
		chk(16'(pitch_active), 16'h0000, "close");
		$display("Test pitch done");
	endtask
	task t_invert;
		@(negedge sys_clk);
		rst_n = 1'b0;
		fs_invert = 1'b1;
		nv_offset = 16'h7FFF;
		repeat (6) @(negedge sys_clk);
		rst_n = 1'b1;
		repeat (3) @(negedge sys_clk);
		chk(16'(variable_pitch_select), 16'h0000, "var");
		chk(rate_request, 16'h2710, "rate");
		chk(pitch_offset, 16'h04B4, "keep");
		hit(5, TFPC_STOP);
		hit(8, TFPC_STOP);
		hit(9, TFPC_STOP);
		chk(display_offset, 16'h04B4, "disp");
		chk(rate_request, 16'h2BC4, "rate");
		hit(10, TFPC_STOP);
		chk(pitch_offset, 16'h04B3, "keep");
		hit(6, TFPC_STOP);
		go(FS, TFPC_PLAY, {OF, OF, ON});
		$display("Test invert done");
	endtask
	////////////////////////////////////////////////////////////////////
	// Main sequence
	initial
	begin
		repeat (6) @(negedge sys_clk);
		rst_n = 1'b1;
		repeat (3) @(negedge sys_clk);
		chk(16'(mode), 16'(TFPC_STOP), "mode");
		chk(rate_request, 16'h2710, "rate");
		chk(pitch_offset, 16'hFB4E, "keep");
		t_playback();
		t_punch();
		t_new_rec();
		t_auto();
		t_pitch();
		t_invert();
		close_out();
	end
	// Watchdog
	initial
	begin
		#1000000;
		fail_count++;
		close_out();
	end
endmodule // tfpc_top_test
`default_nettype wire
